// ==== pkg/dfc_pkg.sv ====
package dfc_pkg;

	// Terminal function codes (decimal codes written in hex)
	localparam logic [7:0] FN_JOG       = 8'h06;
	localparam logic [7:0] FN_SET2      = 8'h08;
	localparam logic [7:0] FN_LOCK      = 8'h0F;
	localparam logic [7:0] FN_THIRD_MOTOR_SELECT      = 8'h11;
	localparam logic [7:0] FN_NONE      = 8'hFF;

	// Jog stop modes: 0..2 forbid jog while running, 3..5 allow it
	localparam logic [2:0] JOG_MODE_ALLOW = 3'h3;
	localparam logic [2:0] JOG_MODE_MAX   = 3'h5;

	// Lock modes (mode ten is written in hex)
	localparam logic [7:0] LOCK_SW_ALL   = 8'h00;
	localparam logic [7:0] LOCK_SW_FREQ  = 8'h01;
	localparam logic [7:0] LOCK_ALL      = 8'h02;
	localparam logic [7:0] LOCK_FREQ     = 8'h03;
	localparam logic [7:0] LOCK_RUNCHG   = 8'h0A;

	// Jog frequency in 0.01 Hz units
	localparam logic [9:0] JOG_FREQ_MAX  = 10'h3E7;
	localparam logic [9:0] START_FREQ    = 10'h032;

	localparam logic [1:0] MSET_FIRST    = 2'h1;
	localparam logic [1:0] MSET_SECOND   = 2'h2;
	localparam logic [1:0] MSET_THIRD    = 2'h3;

	// Register byte offsets
	localparam logic [7:0] ADDR_FUNC_LO  = 8'h00;
	localparam logic [7:0] ADDR_FUNC_HI  = 8'h04;
	localparam logic [7:0] ADDR_JOG_FREQ = 8'h08;
	localparam logic [7:0] ADDR_JOG_MODE = 8'h0C;
	localparam logic [7:0] ADDR_LOCK     = 8'h10;
	localparam logic [7:0] ADDR_STATUS   = 8'h14;

	// Reset values
	localparam logic [63:0] RST_FUNC      = 64'hFFFFFFFFFFFFFFFF;
	localparam logic [9:0]  RST_JOG_FREQ  = 10'h000;
	localparam logic [2:0]  RST_JOG_MODE  = 3'h0;
	localparam logic [7:0]  RST_LOCK_MODE = 8'h00;

	// Status field positions
	localparam int ST_MSET    = 0;
	localparam int ST_JOG     = 2;
	localparam int ST_LOCKIN  = 3;
	localparam int ST_STOP    = 4;
	localparam int ST_WLOCK   = 6;
	localparam int ST_TERM    = 8;
	localparam int ST_FWD     = 16;
	localparam int ST_REV     = 17;

	typedef enum logic [1:0] {JOG_IDLE, JOG_RUN, JOG_BLOCK} dfc_jog_type;
	typedef enum logic [1:0] {STOP_NONE, STOP_FREE, STOP_DECEL, STOP_DCB} dfc_stop_type;

endpackage

// ==== hw/dfc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module dfc_sync
	import dfc_pkg::*;
#(
	parameter int W = 10
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dfc_sync_type;

	dfc_sync_type st_reg;
	dfc_sync_type st_next;

	always_comb begin
		st_next.s1 = async_in;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.s2;
endmodule
`default_nettype wire

// ==== hw/dfc_func_match.sv ====
`timescale 1ns/1ps
`default_nettype none
module dfc_func_match
	import dfc_pkg::*;
#(
	parameter logic [7:0] CODE = 8'h06
) (
	input  wire logic [63:0] func_codes,
	input  wire logic [7:0]  terms,
	output logic             hit
);
	// Any terminal assigned this code and currently on
	always_comb begin
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (func_codes[i*8 +: 8] == CODE && terms[i]) begin
				hit = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hw/dfc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dfc_top
	import dfc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  term_pin,
	input  wire logic        forward_run_input,
	input  wire logic        reverse_run_input,
	input  wire logic        motor_running,
	output logic             jog_active,
	output logic      [9:0]  freq_out,
	output logic             stop_pulse,
	output logic      [1:0]  stop_kind,
	output logic      [1:0]  motor_set,
	output logic             write_lock_active
);
	typedef struct packed {
		logic [63:0]  func;
		logic [9:0]   jog_freq;
		logic [2:0]   jog_mode;
		logic [7:0]   lock_mode;
		dfc_jog_type  jog_st;
		logic         run_prev;
		dfc_stop_type stop_kind;
		logic         stop_pulse;
		logic         jog_active;
		logic [9:0]   freq_out;
		logic [1:0]   motor_set;
		logic         wlock;
		logic         pready;
		logic         pslverr;
		logic [31:0]  prdata;
	} dfc_state_type;

	dfc_state_type st_reg;
	dfc_state_type st_next;

	logic [9:0] sync_bus;
	logic [7:0] terms;
	logic       fwd_in;
	logic       rev_in;
	logic       run_in;
	logic       jog_input;
	logic       second_motor_select;
	logic       third_motor_select;
	logic       parameter_lock_input;
	logic       allow_run;
	logic       lock_other;
	logic       lock_freq;
	logic       wr_done;
	logic       rd_err;
	logic       wr_err;
	logic [31:0] rdata;

	dfc_sync #(
		.W (10)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({reverse_run_input, forward_run_input, term_pin}),
		.sync_out (sync_bus)
	);

	assign terms  = sync_bus[7:0];
	assign fwd_in = sync_bus[8];
	assign rev_in = sync_bus[9];
	assign run_in = fwd_in | rev_in;

	dfc_func_match #(.CODE(FN_JOG)) u_jog (
		.func_codes (st_reg.func),
		.terms      (terms),
		.hit        (jog_input)
	);

	dfc_func_match #(.CODE(FN_SET2)) u_set2 (
		.func_codes (st_reg.func),
		.terms      (terms),
		.hit        (second_motor_select)
	);

	dfc_func_match #(.CODE(FN_THIRD_MOTOR_SELECT)) u_third_motor_select (
		.func_codes (st_reg.func),
		.terms      (terms),
		.hit        (third_motor_select)
	);

	dfc_func_match #(.CODE(FN_LOCK)) u_lock (
		.func_codes (st_reg.func),
		.terms      (terms),
		.hit        (parameter_lock_input)
	);

	assign allow_run = st_reg.jog_mode >= JOG_MODE_ALLOW;

	// Write protection for ordinary settings and for the frequency group
	always_comb begin
		unique case (st_reg.lock_mode)
			LOCK_SW_ALL: begin
				lock_other = parameter_lock_input;
				lock_freq  = parameter_lock_input;
			end
			LOCK_SW_FREQ: begin
				lock_other = parameter_lock_input;
				lock_freq  = 1'b0;
			end
			LOCK_ALL: begin
				lock_other = 1'b1;
				lock_freq  = 1'b1;
			end
			LOCK_FREQ: begin
				lock_other = 1'b1;
				lock_freq  = 1'b0;
			end
			LOCK_RUNCHG: begin
				// Only the jog frequency is changeable during operation here
				lock_other = 1'b1;
				lock_freq  = 1'b0;
			end
			default: begin
				lock_other = 1'b0;
				lock_freq  = 1'b0;
			end
		endcase
	end

	always_comb begin
		rdata  = 32'h00000000;
		rd_err = 1'b0;
		wr_err = 1'b0;
		unique case (paddr)
			ADDR_FUNC_LO: begin
				rdata  = st_reg.func[31:0];
				wr_err = lock_other;
			end
			ADDR_FUNC_HI: begin
				rdata  = st_reg.func[63:32];
				wr_err = lock_other;
			end
			ADDR_JOG_FREQ: begin
				rdata  = {22'h000000, st_reg.jog_freq};
				// Zero, or start frequency up to 9.99 Hz
				wr_err = lock_freq || (pwdata[31:10] != 22'h000000) ||
					(pwdata[9:0] != 10'h000 && (pwdata[9:0] < START_FREQ ||
					pwdata[9:0] > JOG_FREQ_MAX));
			end
			ADDR_JOG_MODE: begin
				rdata  = {29'h00000000, st_reg.jog_mode};
				wr_err = lock_other || (pwdata[31:3] != 29'h00000000) ||
					(pwdata[2:0] > JOG_MODE_MAX);
			end
			ADDR_LOCK: begin
				rdata  = {24'h000000, st_reg.lock_mode};
				wr_err = !(pwdata[7:0] == LOCK_SW_ALL || pwdata[7:0] == LOCK_SW_FREQ ||
					pwdata[7:0] == LOCK_ALL || pwdata[7:0] == LOCK_FREQ ||
					pwdata[7:0] == LOCK_RUNCHG) || (pwdata[31:8] != 24'h000000);
			end
			ADDR_STATUS: begin
				rdata[ST_MSET +: 2] = st_reg.motor_set;
				rdata[ST_JOG]       = st_reg.jog_active;
				rdata[ST_LOCKIN]    = parameter_lock_input;
				rdata[ST_STOP +: 2] = st_reg.stop_kind;
				rdata[ST_WLOCK]     = st_reg.wlock;
				rdata[ST_TERM +: 8] = terms;
				rdata[ST_FWD]       = fwd_in;
				rdata[ST_REV]       = rev_in;
				wr_err              = 1'b1;
			end
			default: begin
				rd_err = 1'b1;
				wr_err = 1'b1;
			end
		endcase
	end

	assign wr_done = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;

	always_comb begin
		st_next            = st_reg;
		st_next.stop_pulse = 1'b0;
		st_next.run_prev   = run_in;
		st_next.wlock      = lock_other;

		// One wait state: answer is staged, then the write commits at the edge that ends the cycle with pready high
		st_next.pready = 1'b0;
		if (psel && penable && !st_reg.pready) begin
			st_next.pready  = 1'b1;
			st_next.prdata  = pwrite ? 32'h00000000 : rdata;
			st_next.pslverr = pwrite ? wr_err : rd_err;
		end
		if (wr_done) begin
			unique case (paddr)
				ADDR_FUNC_LO:  st_next.func[31:0]  = pwdata;
				ADDR_FUNC_HI:  st_next.func[63:32] = pwdata;
				ADDR_JOG_FREQ: st_next.jog_freq    = pwdata[9:0];
				ADDR_JOG_MODE: st_next.jog_mode    = pwdata[2:0];
				ADDR_LOCK:     st_next.lock_mode   = pwdata[7:0];
				default: begin
				end
			endcase
		end

		unique case (st_reg.jog_st)
			JOG_IDLE: begin
				if (jog_input && run_in) begin
					if (allow_run) begin
						st_next.jog_st = JOG_RUN;
					end else if (!st_reg.run_prev && !motor_running) begin
						st_next.jog_st = JOG_RUN;
					end else begin
						st_next.jog_st = JOG_BLOCK;
					end
				end
			end
			JOG_BLOCK: begin
				if (!jog_input || !run_in) begin
					st_next.jog_st = JOG_IDLE;
				end
			end
			JOG_RUN: begin
				if (!jog_input || !run_in) begin
					st_next.jog_st     = JOG_IDLE;
					st_next.stop_pulse = 1'b1;
					if (allow_run && !jog_input && fwd_in) begin
						st_next.stop_kind = STOP_FREE;
					end else begin
						unique case (st_reg.jog_mode)
							3'h0, 3'h3: st_next.stop_kind = STOP_FREE;
							3'h1, 3'h4: st_next.stop_kind = STOP_DECEL;
							default:    st_next.stop_kind = STOP_DCB;
						endcase
					end
				end
			end
		endcase
		st_next.jog_active = st_next.jog_st == JOG_RUN;
		st_next.freq_out   = st_next.jog_active ? st_reg.jog_freq : 10'h000;

		// Parameter set follows the select inputs only at standstill
		if (!motor_running && !st_reg.jog_active) begin
			if (second_motor_select) begin
				st_next.motor_set = MSET_SECOND;
			end else if (third_motor_select) begin
				st_next.motor_set = MSET_THIRD;
			end else begin
				st_next.motor_set = MSET_FIRST;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg           <= '0;
			st_reg.func      <= RST_FUNC;
			st_reg.jog_freq  <= RST_JOG_FREQ;
			st_reg.jog_mode  <= RST_JOG_MODE;
			st_reg.lock_mode <= RST_LOCK_MODE;
			st_reg.jog_st    <= JOG_IDLE;
			st_reg.stop_kind <= STOP_NONE;
			st_reg.motor_set <= MSET_FIRST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata            = st_reg.prdata;
	assign pready            = st_reg.pready;
	assign pslverr           = st_reg.pslverr;
	assign jog_active        = st_reg.jog_active;
	assign freq_out          = st_reg.freq_out;
	assign stop_pulse        = st_reg.stop_pulse;
	assign stop_kind         = st_reg.stop_kind;
	assign motor_set         = st_reg.motor_set;
	assign write_lock_active = st_reg.wlock;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_jog_code_only: assert property ($rose(jog_active) |-> $past(jog_input))
		else $error("jog started without a jog terminal");
	chk_jog_freq_out: assert property (jog_active |-> freq_out == $past(st_reg.jog_freq))
		else $error("jog frequency not output");
	chk_jog_not_running: assert property ($rose(jog_active) && !allow_run |-> !$past(motor_running))
		else $error("jog started while running in mode 0-2");
	chk_jog_order: assert property ($rose(jog_active) && !allow_run |-> !$past(st_reg.run_prev))
		else $error("jog started after run came first");
	chk_free_release: assert property (st_reg.jog_st == JOG_RUN && allow_run && !jog_input && fwd_in
		|=> stop_pulse && stop_kind == STOP_FREE)
		else $error("jog release did not free-run");
	chk_decel_stop: assert property (st_reg.jog_st == JOG_RUN && st_reg.jog_mode == 3'h1 && !run_in
		|=> stop_pulse && stop_kind == STOP_DECEL)
		else $error("mode 1 jog did not decelerate");
	chk_set_priority: assert property (second_motor_select && third_motor_select && !motor_running
		&& !jog_active |=> motor_set == MSET_SECOND)
		else $error("second motor did not take priority");
	chk_set_hold: assert property (motor_running |=> $stable(motor_set))
		else $error("motor set changed while running");
	chk_lock_all: assert property (psel && penable && pready && pwrite && st_reg.lock_mode == LOCK_ALL
		&& paddr != ADDR_LOCK |=> $stable(st_reg.func) && $stable(st_reg.jog_freq) && $stable(st_reg.jog_mode))
		else $error("write landed under full lock");
	chk_lock_input: assert property (psel && penable && !pready && pwrite && paddr == ADDR_JOG_MODE
		&& st_reg.lock_mode == LOCK_SW_ALL && parameter_lock_input |=> pslverr)
		else $error("lock input did not refuse write");

	cov_jog_run:   cover property ($rose(jog_active));
	cov_jog_block: cover property (st_reg.jog_st == JOG_BLOCK);
	cov_free_stop: cover property (stop_pulse && stop_kind == STOP_FREE);
	cov_third_set: cover property (motor_set == MSET_THIRD);
endmodule
`default_nettype wire

// ==== verif/dfc_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dfc_ctrl_model #(
	parameter int GAP = 4
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       jog_cmd,
	input  wire logic [1:0] run_cmd,
	input  wire logic       run_first,
	input  wire logic [6:0] pins,
	output logic      [7:0] term_pin,
	output logic            forward_run_input,
	output logic            reverse_run_input
);
	int         jog_age;
	int         run_age;
	logic       jog_q;
	logic       run_q;
	logic [6:0] pins_q;
	// Run only follows a jog that has stood GAP cycles, unless told to misbehave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			jog_q   <= 1'b0;
			run_q   <= 1'b0;
			jog_age <= 0;
			run_age <= 0;
			pins_q  <= '0;
		end else begin
			jog_age <= jog_q ? jog_age + 1 : 0;
			run_age <= run_q ? run_age + 1 : 0;
			jog_q   <= jog_cmd && (jog_q || !run_first || run_age >= GAP);
			run_q   <= (|run_cmd) && (run_q || run_first || jog_age >= GAP);
			pins_q  <= pins;
		end
	end
	assign term_pin          = {pins_q, jog_q};
	assign forward_run_input = run_q && run_cmd[0];
	assign reverse_run_input = run_q && run_cmd[1];
endmodule
`default_nettype wire

// ==== verif/test_drive_input_function_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_drive_input_function_control
	import dfc_pkg::*;
;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0, term_pin;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, err, fwd, rev, jog_active, stop_pulse, write_lock_active;
	logic        jog_cmd = 0, run_first = 0, mrun = 0;
	logic [1:0]  run_cmd = 0, stop_kind, motor_set;
	logic [6:0]  pins = 0;
	logic [9:0]  freq_out, jf;
	int          n_fail = 0, checks = 0, cyc = 0, n_stop = 0, m, l, k, jm = 0;
	int          lmodes[5] = '{0, 1, 2, 3, 10};

	dfc_ctrl_model ctl (.pclk(pclk), .presetn(presetn), .jog_cmd(jog_cmd), .run_cmd(run_cmd),
		.run_first(run_first), .pins(pins), .term_pin(term_pin), .forward_run_input(fwd),
		.reverse_run_input(rev));
	dfc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.term_pin(term_pin), .forward_run_input(fwd), .reverse_run_input(rev),
		.motor_running(mrun), .jog_active(jog_active), .freq_out(freq_out),
		.stop_pulse(stop_pulse), .stop_kind(stop_kind), .motor_set(motor_set),
		.write_lock_active(write_lock_active));

	always #20 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc++;
		if (stop_pulse === 1'b1)
			n_stop++;
		if (cyc == 30000) begin
			n_fail++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk(err, e);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 0);
		chk(rd, e);
	endtask

	// Model of the write protection, by lock mode, lock input and register class
	function automatic logic blocked(input int mode, input int lin, input logic [7:0] a);
		logic fq;
		fq = (a == ADDR_JOG_FREQ);
		if (a == ADDR_LOCK)
			return 1'b0;
		case (mode)
			0: return lin != 0;
			1: return lin != 0 && !fq;
			2: return 1'b1;
			3, 10: return !fq;
			default: return 1'b0;
		endcase
	endfunction

	// Jog on and run on, then check the outcome after sync and response delays
	task automatic jog_try(input logic rf, input logic [1:0] dir, input logic on);
		run_first <= rf;
		jog_cmd   <= 1'b1;
		run_cmd   <= dir;
		repeat (14) @(posedge pclk);
		chk(jog_active, on);
		chk(freq_out, on ? jf : 10'h000);
	endtask

	// Release one input first, then the other; exactly one stop when jogging
	task automatic rel(input logic jog_first, input int kind, input int stops);
		int s;
		s = n_stop;
		if (jog_first)
			jog_cmd <= 1'b0;
		else
			run_cmd <= 2'b00;
		repeat (8) @(posedge pclk);
		chk(jog_active, 1'b0);
		if (stops > 0)
			chk(stop_kind, kind);
		jog_cmd   <= 1'b0;
		run_cmd   <= 2'b00;
		run_first <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(n_stop - s, stops);
	endtask

	initial begin
		void'($urandom(32'h9f1b23b3));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chk(motor_set, MSET_FIRST);
		rdc(ADDR_FUNC_LO, 32'hFFFFFFFF);
		rdc(ADDR_FUNC_HI, 32'hFFFFFFFF);
		rdc(ADDR_JOG_FREQ, 0);
		rdc(ADDR_JOG_MODE, 0);
		rdc(ADDR_LOCK, 0);
		rdc(8'h40, 0);
		chk(err, 1'b1);
		wr(ADDR_STATUS, 0, 1'b1);
		wr(ADDR_JOG_MODE, 6, 1'b1);
		wr(ADDR_LOCK, 4, 1'b1);
		wr(ADDR_JOG_FREQ, 10'h031, 1'b1);
		wr(ADDR_JOG_FREQ, 10'h3E8, 1'b1);
		wr(ADDR_JOG_FREQ, 10'h3E7, 1'b0);
		wr(ADDR_JOG_FREQ, 10'h000, 1'b0);
		jf = 10'h000;
		jog_try(1'b0, 2'b01, 1'b0);
		rel(1'b1, 0, 0);
		wr(ADDR_FUNC_LO, 32'h0F110806, 1'b0);
		jog_try(1'b0, 2'b01, 1'b1);
		rel(1'b1, 1, 1);
		for (m = 0; m < 6; m++) begin
			jf = 10'h032 + 10'($urandom % 950);
			wr(ADDR_JOG_FREQ, 32'(jf), 1'b0);
			wr(ADDR_JOG_MODE, m, 1'b0);
			jog_try(1'b0, m[0] ? 2'b10 : 2'b01, 1'b1);
			rel(1'b0, (m % 3) + 1, 1);
			jog_try(1'b0, 2'b01, 1'b1);
			rel(1'b1, m < 3 ? (m % 3) + 1 : 1, 1);
			jog_try(1'b1, 2'b01, m >= 3);
			rel(1'b1, 1, m >= 3 ? 1 : 0);
			mrun <= 1'b1;
			jog_try(1'b0, 2'b01, m >= 3);
			rel(1'b0, (m % 3) + 1, m >= 3 ? 1 : 0);
			mrun <= 1'b0;
		end
		pins <= 7'h02;
		repeat (6) @(posedge pclk);
		chk(motor_set, MSET_THIRD);
		pins <= 7'h03;
		repeat (6) @(posedge pclk);
		chk(motor_set, MSET_SECOND);
		mrun <= 1'b1;
		pins <= 7'h00;
		repeat (6) @(posedge pclk);
		chk(motor_set, MSET_SECOND);
		mrun <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(motor_set, MSET_FIRST);
		wr(ADDR_FUNC_LO, 32'hFF110806, 1'b0);
		pins <= 7'h04;
		repeat (6) @(posedge pclk);
		wr(ADDR_JOG_MODE, 0, 1'b0);
		wr(ADDR_FUNC_LO, 32'h0F110806, 1'b0);
		for (k = 0; k < 10; k++) begin
			m = lmodes[k / 2];
			l = k % 2;
			wr(ADDR_LOCK, m, 1'b0);
			pins <= l ? 7'h04 : 7'h00;
			repeat (6) @(posedge pclk);
			chk(write_lock_active, blocked(m, l, ADDR_JOG_MODE));
			wr(ADDR_JOG_MODE, k % 6, blocked(m, l, ADDR_JOG_MODE));
			if (!blocked(m, l, ADDR_JOG_MODE))
				jm = k % 6;
			rdc(ADDR_JOG_MODE, jm);
			wr(ADDR_JOG_FREQ, 32'(START_FREQ) + k, blocked(m, l, ADDR_JOG_FREQ));
			if (!blocked(m, l, ADDR_JOG_FREQ))
				jf = START_FREQ + 10'(k);
			rdc(ADDR_JOG_FREQ, 32'(jf));
		end
		wr(ADDR_LOCK, 0, 1'b0);
		results();
	end
endmodule
`default_nettype wire
